// File: kex_regs.vh
`ifndef KEX_REGS_VH
`define KEX_REGS_VH
`define OFF_REQ_LINK 8'h00
`define OFF_REQ_HDR 8'h04
`define OFF_CMD 8'h08
`define OFF_NEW_COOKIE 8'h0C
`define OFF_RESP_W0 8'h10
`define OFF_RESP_W1 8'h14
`define OFF_STATUS 8'h18
`define OFF_COOKIE 8'h1C
`define OFF_PARAMS 8'h20
`define OFF_RESP_LEN 8'h24
`define ADDR_W 8
`define TYPE_MAIN 2'h0
`define TYPE_QUICK 2'h1
`define TYPE_EXPL 2'h2
`define SRC_NONE 2'h0
`define SRC_DH 2'h1
`define SRC_COOKIE 2'h2
`define SRC_EXPL 2'h3
`define CMD_GO 0
`define CMD_CONFIRM 1
`define FL_SLOT 0
`define FL_BUMP 1
`define FL_RENEW 2
`define MAIN_RSV_MASK 8'hF0
`define QE_RSV_MASK 8'hFC
`define KIDX_HI 7
`define KIDX_LO 2
`define LINK_ZERO 32'h0000_0000
`define ZERO8 8'h00
`define ZERO16 16'h0000
`define ONE8 8'h01
`define NONCE_LEN_RST 8'h08
`define AUTH_LEN_RST 8'h14
`define PUB_LEN_RST 8'h40
`define KEY_LEN_RST 8'h10
`define HDR_BYTES 8'h06
`define TYPE_HI 25
`define TYPE_LO 24
`define B0_HI 7
`define B0_LO 0
`define B1_HI 15
`define B1_LO 8
`define NLEN_HI 7
`define NLEN_LO 0
`define ALEN_HI 15
`define ALEN_LO 8
`define PLEN_HI 23
`define PLEN_LO 16
`define ERR_LINK 0
`define ERR_FLAG 1
`define ERR_BYTE 2
`define KIDX_RSV_MASK 8'h03
`define ZERO32 32'h0000_0000
`define ZERO6 6'h00
`endif

// File: key_exchange_msg_handler.v
`timescale 1ns/10ps
`default_nettype none
`include "kex_regs.vh"
// Summary of operation
// - link identifier is 32 zero bits in requests and responses.
// - main response: identifier, flag byte, clone counter, nonce, auth, public value.
// - renew-cookie: new cookie, flip cookie seq bit, zero counter, clear counter seq.
// - bump-counter: counter plus one modulo 256, flip counter seq bit.
// - updates stay pending until connect-confirm; only then committed to storage.
// - every response reports present counter and counter seq bit.
// - session-key select bit picks key slot 0 or 1 to update.
// - quick response has main fields except the public value.
// - main exchange derives key and cookie from private value and fields.
// - quick exchange derives session key from working (uncommitted) cookie and fields.
// - explicit key installed into context named by key index.
// - counter-mode nonces precede encrypted key, one per direction.
// - field lengths follow negotiated parameters, not fixed sizes.
// - cookie seq bit names cookie generation used for authentication.
// - baseline nonce length is 8 bytes.
module key_exchange_msg_handler (
  input wire I_REF_CLK,
  input wire I_RESETN,
  input wire I_PSEL,
  input wire I_PENABLE,
  input wire I_PWRITE,
  input wire [31:0] I_PADDR,
  input wire [31:0] I_PWDATA,
  input wire [3:0] I_PSTRB,
  output wire [31:0] O_PRDATA,
  output wire O_PREADY,
  output wire O_PSLVERR,
  output wire O_KEY_LOAD,
  output wire O_KEY_SLOT,
  output wire [5:0] O_KEY_CTX,
  output wire [1:0] O_KEY_SRC,
  output wire [31:0] O_AUTH_COOKIE,
  output wire O_NV_WRITE,
  output wire [7:0] O_NV_COUNTER,
  output wire [1:0] O_NV_SEQ,
  output wire [31:0] O_NV_COOKIE
);
  wire [`ADDR_W-1:0] addr;
  wire wr;
  wire rd;
  reg [31:0] req_link_r;
  reg [31:0] req_hdr_r;
  reg [31:0] new_cookie_r;
  reg [31:0] params_r;
  reg [7:0] wrk_cnt_r;
  reg wrk_cnt_sq_r;
  reg wrk_ck_sq_r;
  reg [31:0] wrk_cookie_r;
  reg [7:0] cmt_cnt_r;
  reg cmt_cnt_sq_r;
  reg cmt_ck_sq_r;
  reg [31:0] cmt_cookie_r;
  reg pending_r;
  reg [2:0] err_r;
  reg resp_valid_r;
  reg resp_main_r;
  reg [7:0] resp_flags_r;
  reg [7:0] resp_cnt_r;
  reg key_load_r;
  reg key_slot_r;
  reg [5:0] key_ctx_r;
  reg [1:0] key_src_r;
  reg [31:0] auth_cookie_r;
  reg nv_write_r;
  reg [31:0] rdata;
  reg [7:0] wrk_cnt_nxt;
  reg wrk_cnt_sq_nxt;
  reg wrk_ck_sq_nxt;
  reg [31:0] wrk_cookie_nxt;
  reg changed;
  reg [2:0] err_nxt;
  reg [7:0] flags;
  reg [5:0] kidx;
  reg [1:0] src;
  reg mapped;
  wire [1:0] req_type;
  wire [7:0] byte0;
  wire [7:0] byte1;
  wire go;
  wire confirm;
  wire [7:0] nonce_len;
  wire [7:0] auth_len;
  wire [7:0] public_value_len;
  wire [7:0] resp_len;
  wire [31:0] resp_w1_word;
  wire [31:0] status_word;

  assign addr = I_PADDR[`ADDR_W-1:0];
  assign wr = I_PSEL & I_PENABLE & I_PWRITE;
  assign rd = I_PSEL & ~I_PWRITE;
  // zero wait states: every access completes in its first access cycle
  assign O_PREADY = 1'b1;
  // unmapped access flags an error and no write lands
  assign O_PSLVERR = I_PSEL & I_PENABLE & ~mapped;
  assign O_PRDATA = rdata;

  assign req_type = req_hdr_r[`TYPE_HI:`TYPE_LO];
  assign byte0 = req_hdr_r[`B0_HI:`B0_LO];
  assign byte1 = req_hdr_r[`B1_HI:`B1_LO];
  // go and confirm may share one write; both then act
  assign go = wr & (addr == `OFF_CMD) & I_PSTRB[0] & I_PWDATA[`CMD_GO];
  assign confirm = wr & (addr == `OFF_CMD) & I_PSTRB[0] &
                   I_PWDATA[`CMD_CONFIRM];
  assign nonce_len = params_r[`NLEN_HI:`NLEN_LO];
  assign auth_len = params_r[`ALEN_HI:`ALEN_LO];
  assign public_value_len = params_r[`PLEN_HI:`PLEN_LO];
  // lengths come from negotiated parameters
  assign resp_len = `HDR_BYTES + nonce_len + auth_len +
                    (resp_main_r ? public_value_len : `ZERO8);

  // first transmitted byte sits in bits 31:24
  assign resp_w1_word = {resp_flags_r,
                         resp_cnt_r,
                         `ZERO16};
  // one field per line so the status layout reads at a glance
  assign status_word = {2'h0,
                        key_ctx_r,
                        resp_valid_r,
                        key_slot_r,
                        err_r,
                        pending_r,
                        cmt_ck_sq_r,
                        cmt_cnt_sq_r,
                        `ZERO8,
                        cmt_cnt_r};

  always @* begin
    wrk_cnt_nxt = wrk_cnt_r;
    wrk_cnt_sq_nxt = wrk_cnt_sq_r;
    wrk_ck_sq_nxt = wrk_ck_sq_r;
    wrk_cookie_nxt = wrk_cookie_r;
    changed = 1'b0;
    err_nxt = 3'b000;
    flags = byte0;
    kidx = `ZERO6;
    src = `SRC_NONE;
    // explicit request carries key index byte before flags
    if (req_type == `TYPE_EXPL) begin
      flags = byte1;
      kidx = byte0[`KIDX_HI:`KIDX_LO];
    end
    err_nxt[`ERR_LINK] = (req_link_r != `LINK_ZERO);
    case (req_type)
      `TYPE_MAIN: begin
        err_nxt[`ERR_FLAG] = |(flags & `MAIN_RSV_MASK);
        err_nxt[`ERR_BYTE] = (byte1 != `ZERO8);
        src = `SRC_DH;
      end
      `TYPE_QUICK: begin
        err_nxt[`ERR_FLAG] = |(flags & `QE_RSV_MASK);
        err_nxt[`ERR_BYTE] = (byte1 != `ZERO8);
        src = `SRC_COOKIE;
      end
      `TYPE_EXPL: begin
        err_nxt[`ERR_FLAG] = |(flags & `QE_RSV_MASK);
        err_nxt[`ERR_BYTE] = |(byte0 & `KIDX_RSV_MASK);
        // key engine expects nonces ahead of ciphered key
        src = `SRC_EXPL;
      end
      default: begin
        err_nxt[`ERR_FLAG] = 1'b1;
      end
    endcase
    if (go && (err_nxt == 3'b000)) begin
      // renew first so a bump in the same request counts from zero
      if ((req_type == `TYPE_MAIN) && flags[`FL_RENEW]) begin
        wrk_cookie_nxt = new_cookie_r;
        wrk_ck_sq_nxt = ~wrk_ck_sq_r;
        wrk_cnt_nxt = `ZERO8;
        wrk_cnt_sq_nxt = 1'b0;
        changed = 1'b1;
      end
      if (flags[`FL_BUMP]) begin
        wrk_cnt_nxt = wrk_cnt_nxt + `ONE8; // wraps at 256
        wrk_cnt_sq_nxt = ~wrk_cnt_sq_nxt;
        changed = 1'b1;
      end
    end
  end

  always @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      req_link_r <= `LINK_ZERO;
      req_hdr_r <= `ZERO32;
      new_cookie_r <= `ZERO32;
      params_r <= {`KEY_LEN_RST, `PUB_LEN_RST, `AUTH_LEN_RST,
                   `NONCE_LEN_RST};
    end else if (wr) begin
      case (addr)
        `OFF_REQ_LINK: req_link_r <= I_PWDATA;
        `OFF_REQ_HDR: req_hdr_r <= I_PWDATA;
        `OFF_NEW_COOKIE: new_cookie_r <= I_PWDATA;
        `OFF_PARAMS: params_r <= I_PWDATA;
        default: req_link_r <= req_link_r;
      endcase
    end
  end

  always @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      wrk_cnt_r <= `ZERO8;
      wrk_cnt_sq_r <= 1'b0;
      wrk_ck_sq_r <= 1'b0;
      wrk_cookie_r <= `ZERO32;
      cmt_cnt_r <= `ZERO8;
      cmt_cnt_sq_r <= 1'b0;
      cmt_ck_sq_r <= 1'b0;
      cmt_cookie_r <= `ZERO32;
      pending_r <= 1'b0;
      err_r <= 3'b000;
      resp_valid_r <= 1'b0;
      resp_main_r <= 1'b0;
      resp_flags_r <= `ZERO8;
      resp_cnt_r <= `ZERO8;
      key_load_r <= 1'b0;
      key_slot_r <= 1'b0;
      key_ctx_r <= `ZERO6;
      key_src_r <= `SRC_NONE;
      auth_cookie_r <= `ZERO32;
      nv_write_r <= 1'b0;
    end else begin
      key_load_r <= 1'b0;
      nv_write_r <= 1'b0;
      // working copy carries chained requests ahead of confirm
      wrk_cnt_r <= wrk_cnt_nxt;
      wrk_cnt_sq_r <= wrk_cnt_sq_nxt;
      wrk_ck_sq_r <= wrk_ck_sq_nxt;
      wrk_cookie_r <= wrk_cookie_nxt;
      if (go) begin
        err_r <= err_nxt;
        // a refused request leaves no response and no key update
        resp_valid_r <= (err_nxt == 3'b000);
        if (err_nxt == 3'b000) begin
          resp_main_r <= (req_type == `TYPE_MAIN);
          resp_flags_r <= {6'b00_0000, wrk_ck_sq_nxt,
                           wrk_cnt_sq_nxt};
          resp_cnt_r <= wrk_cnt_nxt;
          key_load_r <= 1'b1;
          key_slot_r <= flags[`FL_SLOT];
          key_ctx_r <= kidx;
          key_src_r <= src;
          auth_cookie_r <= wrk_cookie_nxt;
        end
      end
      // confirm beside a change commits both together, nothing is lost
      if (confirm) begin
        cmt_cnt_r <= wrk_cnt_nxt;
        cmt_cnt_sq_r <= wrk_cnt_sq_nxt;
        cmt_ck_sq_r <= wrk_ck_sq_nxt;
        cmt_cookie_r <= wrk_cookie_nxt;
        nv_write_r <= pending_r | changed;
        pending_r <= 1'b0;
      end else if (changed) begin
        pending_r <= 1'b1;
      end
    end
  end

  always @* begin
    rdata = `ZERO32;
    mapped = 1'b1;
    case (addr)
      `OFF_REQ_LINK: rdata = req_link_r;
      `OFF_REQ_HDR: rdata = req_hdr_r;
      `OFF_CMD: rdata = `ZERO32;
      `OFF_NEW_COOKIE: rdata = new_cookie_r;
      `OFF_RESP_W0: rdata = `LINK_ZERO;
      `OFF_RESP_W1: rdata = resp_w1_word;
      `OFF_STATUS: rdata = status_word;
      `OFF_COOKIE: rdata = cmt_cookie_r;
      `OFF_PARAMS: rdata = params_r;
      `OFF_RESP_LEN: rdata = {24'h00_0000, resp_len};
      default: mapped = 1'b0;
    endcase
    // idle bus reads as zero so no stale word leaks out
    if (!rd) begin
      rdata = `ZERO32;
    end
  end

  assign O_KEY_LOAD = key_load_r;
  assign O_KEY_SLOT = key_slot_r;
  assign O_KEY_CTX = key_ctx_r;
  assign O_KEY_SRC = key_src_r;
  assign O_AUTH_COOKIE = auth_cookie_r;
  // storage sees only committed values
  assign O_NV_WRITE = nv_write_r;
  assign O_NV_COUNTER = cmt_cnt_r;
  assign O_NV_SEQ = {cmt_ck_sq_r, cmt_cnt_sq_r};
  assign O_NV_COOKIE = cmt_cookie_r;
endmodule
`default_nettype wire

// File: kex_chk.sv
`timescale 1ns/10ps
`default_nettype none
module kex_chk (
  input wire logic I_REF_CLK,
  input wire logic I_RESETN,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [31:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_KEY_LOAD,
  input wire logic [1:0] O_KEY_SRC,
  input wire logic [5:0] O_KEY_CTX,
  input wire logic O_NV_WRITE,
  input wire logic [7:0] O_NV_COUNTER
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RESETN);
  wire logic acc = I_PSEL && I_PENABLE;
  wire logic [7:0] a = I_PADDR[7:0];
  wire logic cmd = acc && I_PWRITE && a == 8'h08;
  key_one_a: assert property (O_KEY_LOAD |=> !O_KEY_LOAD)
    else $error("key load pulse too long");
  load_cause_a: assert property (O_KEY_LOAD |-> $past(cmd && I_PWDATA[0]))
    else $error("key load without go");
  nv_one_a: assert property (O_NV_WRITE |=> !O_NV_WRITE)
    else $error("commit pulse too long");
  nv_cause_a: assert property (O_NV_WRITE |-> $past(cmd && I_PWDATA[1]))
    else $error("commit without confirm");
  nv_hold_a: assert property (!O_NV_WRITE |-> $stable(O_NV_COUNTER))
    else $error("stored counter moved");
  src_ok_a: assert property (O_KEY_LOAD |-> O_KEY_SRC != 2'h0)
    else $error("key load with no source");
  ctx_zero_a: assert property (O_KEY_LOAD && O_KEY_SRC != 2'h3 |-> O_KEY_CTX == 6'h00)
    else $error("context index outside explicit");
  w0_zero_a: assert property (acc && !I_PWRITE && a == 8'h10 |-> O_PRDATA == 32'h0)
    else $error("identifier word not zero");
  w1_fmt_a: assert property (acc && !I_PWRITE && a == 8'h14 |->
    O_PRDATA[31:26] == 6'h00 && O_PRDATA[15:0] == 16'h0000)
    else $error("flag or pad bits set");
  cover property (O_KEY_LOAD && O_KEY_SRC == 2'h1);
  cover property (O_KEY_LOAD && O_KEY_SRC == 2'h2);
  cover property (O_KEY_LOAD && O_KEY_SRC == 2'h3);
  cover property (O_NV_WRITE);
endmodule
bind key_exchange_msg_handler kex_chk chk_u (.*);
`default_nettype wire

// File: kex_ncc.sv
`timescale 1ns/10ps
`default_nettype none
module kex_ncc (
  input wire logic clk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] paddr,
  output logic [31:0] pwdata
);
  initial begin
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
  end
  // nonces travel outside this model; an unused one stays zero
  // type, flag or key index byte, then next byte of the request
  function automatic [31:0] hdr(input [1:0] t, input [7:0] b0, b1);
    hdr = {6'h00, t, 8'h00, b1, b0};
  endfunction
  task automatic xfer(input wr, input [31:0] ad, d, output [31:0] rd,
      output er);
    int n;
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!pready && n < 16);
    // prdata read before this edge's updates land
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    if (!pready) tb_top.wrap_up(1);
  endtask
endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk, rstn, psel, pen, pwr, prdy, perr, kld, kslot, nvw;
  logic [31:0] padr, pwd, prd, acook, nvck, rd;
  logic [5:0] kctx;
  logic [1:0] ksrc, nvs;
  logic [7:0] nvcnt;
  logic er;
  int miscompares = 0;
  int num_checks = 0;
  key_exchange_msg_handler dut_u (.I_REF_CLK(clk), .I_RESETN(rstn),
    .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(padr),
    .I_PWDATA(pwd), .I_PSTRB(4'hF), .O_PRDATA(prd), .O_PREADY(prdy),
    .O_PSLVERR(perr), .O_KEY_LOAD(kld), .O_KEY_SLOT(kslot),
    .O_KEY_CTX(kctx), .O_KEY_SRC(ksrc), .O_AUTH_COOKIE(acook),
    .O_NV_WRITE(nvw), .O_NV_COUNTER(nvcnt), .O_NV_SEQ(nvs),
    .O_NV_COOKIE(nvck));
  kex_ncc ncc_u (.clk(clk), .prdata(prd), .pready(prdy), .pslverr(perr),
    .psel(psel), .penable(pen), .pwrite(pwr), .paddr(padr), .pwdata(pwd));
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  task automatic wrap_up(input bit hung);
    if (hung) miscompares++;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input [31:0] seen, exp, input string nm);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input [31:0] ad, d);
    ncc_u.xfer(1, ad, d, rd, er);
  endtask
  task automatic rdc(input [31:0] ad, exp, input string nm);
    ncc_u.xfer(0, ad, 32'h0, rd, er);
    chk(rd, exp, nm);
  endtask
  task automatic go(input [1:0] t, input [7:0] b0, b1);
    wr(32'h04, ncc_u.hdr(t, b0, b1));
    wr(32'h08, 32'h1);
    // outputs launched at the access edge are settled by the falling edge
    @(negedge clk);
  endtask
  // status: valid, then reserved byte, flag and link errors
  task automatic errc(input [3:0] exp, input string nm);
    ncc_u.xfer(0, 32'h18, 32'h0, rd, er);
    chk({rd[23], rd[21:19]}, exp, nm);
  endtask
  task automatic t_main;
    wr(32'h00, 32'h0);
    wr(32'h0C, 32'h1234_5678);
    go(0, 8'h06, 8'h00);
    chk(kld, 1'b1, "key_load");
    rdc(32'h14, 32'h0301_0000, "resp_w1");
    rdc(32'h10, 32'h0, "resp_w0");
    rdc(32'h24, 32'h62, "resp_len");
    rdc(32'h1C, 32'h0, "cookie_held");
    chk(ksrc, 2'h1, "key_src");
    $display("main done");
  endtask
  task automatic t_quick;
    go(1, 8'h03, 8'h00);
    chk(kld, 1'b1, "key_load");
    chk(nvw, 1'b0, "nv_idle");
    rdc(32'h14, 32'h0202_0000, "resp_w1");
    rdc(32'h24, 32'h22, "resp_len");
    chk(kslot, 1'b1, "key_slot");
    chk(ksrc, 2'h2, "key_src");
    chk(acook, 32'h1234_5678, "auth_cookie");
    chk(nvcnt, 8'h00, "nv_counter");
    $display("quick done");
  endtask
  task automatic t_confirm;
    ncc_u.xfer(1, 32'h08, 32'h2, rd, er);
    @(negedge clk);
    chk(nvw, 1'b1, "nv_write");
    chk(nvck, 32'h1234_5678, "nv_cookie");
    rdc(32'h1C, 32'h1234_5678, "cookie");
    chk(nvcnt, 8'h02, "nv_counter");
    chk(nvs, 2'b10, "nv_seq");
    $display("confirm done");
  endtask
  task automatic t_expl;
    go(2, 8'h14, 8'h02);
    chk(kld, 1'b1, "key_load");
    chk(kslot, 1'b0, "key_slot");
    chk(kctx, 6'h05, "key_ctx");
    chk(ksrc, 2'h3, "key_src");
    rdc(32'h14, 32'h0303_0000, "resp_w1");
    $display("explicit done");
  endtask
  task automatic t_err;
    wr(32'h00, 32'h1);
    go(0, 8'h00, 8'h00);
    chk(kld, 1'b0, "no_load");
    errc(4'b0001, "link_err");
    wr(32'h00, 32'h0);
    go(0, 8'h10, 8'h00);
    errc(4'b0010, "flag_rsv");
    go(1, 8'h00, 8'h01);
    errc(4'b0100, "byte_rsv");
    go(3, 8'h00, 8'h00);
    chk(kld, 1'b0, "no_load");
    errc(4'b0010, "bad_type");
    ncc_u.xfer(0, 32'h40, 32'h0, rd, er);
    chk(er, 1'b1, "unmapped_err");
    chk(rd, 32'h0, "unmapped_rd");
    $display("error done");
  endtask
  task automatic t_params;
    wr(32'h20, 32'h1030_2010);
    rdc(32'h20, 32'h1030_2010, "params");
    go(0, 8'h00, 8'h00);
    chk(kld, 1'b1, "key_load");
    rdc(32'h24, 32'h66, "resp_len");
    wr(32'h04, ncc_u.hdr(1, 8'h02, 8'h00));
    ncc_u.xfer(1, 32'h08, 32'h3, rd, er);
    @(negedge clk);
    chk(nvw, 1'b1, "nv_write");
    chk(nvcnt, 8'h04, "nv_counter");
    chk(nvs, 2'b10, "nv_seq");
    $display("params done");
  endtask
  initial begin
    rstn = 0;
    repeat (20) @(posedge clk);
    rstn <= 1;
    t_main();
    t_quick();
    t_confirm();
    t_expl();
    t_err();
    t_params();
    wrap_up(0);
  end
endmodule
`default_nettype wire
